// *** mtsr_edge.sv ***
// Rising-edge detector for a synchronised level
module mtsr_edge (
   input  wire logic mclk_i,   // Clock
   input  wire logic rst_n_i,  // Sync reset, active low
   input  wire logic lvl_i,    // Synchronised level
   output logic      rise_o    // One-cycle pulse on rise
);
   logic prev_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) prev_q <= 1'b0;
      else prev_q <= lvl_i;
   end
   assign rise_o = lvl_i & ~prev_q;
endmodule : mtsr_edge

// *** mtsr_pkg.sv ***
// Types shared by the measurement timer files
package mtsr_pkg;
   typedef logic [23:0] mtsr_word_t;
   typedef logic [4:0]  mtsr_code_t;

   // APB request as seen by the slave
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [13:0] addr;
      logic [31:0] wdata;
   } mtsr_apb_s;

   // Counter control state
   typedef enum logic [1:0] {
      MTSR_IDLE = 2'b00,
      MTSR_RUN  = 2'b01,
      MTSR_HALT = 2'b11
   } mtsr_state_e;
endpackage : mtsr_pkg

// *** mtsr_regs.svh ***
// Register offsets, field positions and reset values of the measurement timer
`ifndef MTSR_REGS_SVH
`define MTSR_REGS_SVH

// Register indices (byte address is four times the index)
`define MTSR_IDX_COUNT      12'h48c
`define MTSR_IDX_CPERIOD    12'h48f
`define MTSR_IDX_CWIDTH     12'h492
`define MTSR_IDX_PERIOD     12'h495
`define MTSR_IDX_CTRL       12'h498
`define MTSR_IDX_STATUS     12'h49a
`define MTSR_IDX_SIGSEL     12'h49c
`define MTSR_IDX_WINSEL     12'h49d
// Field positions
`define MTSR_SEL_MSB        4
`define MTSR_CTRL_EN        7
`define MTSR_CTRL_HALT      5
`define MTSR_CTRL_GO        0
`define MTSR_STAT_PRUP      7
`define MTSR_STAT_PWUP      6
`define MTSR_STAT_MATCH     0
// Reset values and code limits
`define MTSR_COUNT_RST      24'h000000
`define MTSR_PERIOD_RST     24'hffffff
`define MTSR_WIN_FIRST_RSV  5'h19
`define MTSR_SIG_FIRST_RSV  5'h18
`define MTSR_WIN_PIN        5'h00
`define MTSR_SIG_PIN        5'h00
`define MTSR_WIN_OVF        5'h16
`define MTSR_SIG_OVF        5'h17

`endif

// *** mtsr_src_model.sv ***
// Behavioural model of the sources feeding the selectors
module mtsr_src_model (
   input  wire logic   mclk_i, // Clock
   output logic [47:0] src_o   // Sibling, pins, window, signal
);
   int seed = 32'hbe25e22f;
   // Fresh levels each cycle so stale routing shows
   initial src_o = 48'h0;
   always @(posedge mclk_i) src_o <= {$random(seed), 16'($random(seed))};
endmodule : mtsr_src_model

// *** mtsr_src_mux.sv ***
// Five-bit source selector with per-source synchroniser and reserved-code masking
`include "mtsr_regs.svh"
module mtsr_src_mux #(
   parameter int          N_SRC     = 24,
   parameter logic [4:0]  FIRST_RSV = 5'h19
) (
   input  wire logic              mclk_i,   // Clock
   input  wire logic              rst_n_i,  // Sync reset, active low
   input  wire logic [N_SRC-1:0]  src_i,    // Sources, index = code
   input  wire mtsr_pkg::mtsr_code_t code_i, // Select code
   output logic                   sel_o     // Selected, synchronised
);
   logic [N_SRC-1:0] meta_q;
   logic [N_SRC-1:0] sync_q;
   logic             sel_d;
   logic             sel_q;
   wire              code_rsv = (code_i >= FIRST_RSV);

   ////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser per source bit
   genvar g;
   generate
      for (g = 0; g < N_SRC; g = g + 1) begin : g_sync
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= src_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // Reserved codes give an idle input
   assign sel_d = (code_rsv || (int'(code_i) >= N_SRC)) ? 1'b0 : sync_q[code_i];

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) sel_q <= 1'b0;
      else sel_q <= sel_d;
   end
   assign sel_o = sel_q;
endmodule : mtsr_src_mux

// *** mtsr_top.sv ***
// Measurement timer: source selectors, count and captured result registers
//
// Our own choice: the APB register port.
`include "mtsr_regs.svh"
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Window code zero takes routed window pin
// - Window codes map sources; 11001 up reserved
// - Signal select is bits 4:0
// - Signal codes map sources; 11000 up reserved
// - Signal code zero takes own routed pin
// - Count is 24-bit, read/write, resets zero
// - Captured period is read-only 24 bits
// - Captured width is read-only, same layout
// - Captured values zero after power-on
// - Other resets keep captured values
// - Count wraps to zero on period match; halt holds it
// - Enable clear resets internal state
// - Period load request clears when done
module mtsr_top (
   input  wire logic        mclk_i,          // 250 MHz clock
   input  wire logic        rst_n_i,         // Sync reset, active low
   input  wire logic        por_n_i,         // Power-on/brown-out, active low
   input  wire logic        psel_i,          // APB select
   input  wire logic        penable_i,       // APB enable
   input  wire logic        pwrite_i,        // APB write
   input  wire logic [13:0] paddr_i,         // APB byte address
   input  wire logic [31:0] pwdata_i,        // APB write data
   output logic [31:0]      prdata_o,        // APB read data
   output logic             pready_o,        // APB ready
   output logic             pslverr_o,       // APB error
   input  wire logic        window_pin_i,    // Routed window pin
   input  wire logic        signal_pin_i,    // Routed signal pin
   input  wire logic [22:0] win_src_i,       // Window sources, codes 1..21 and 23..24
   input  wire logic [21:0] sig_src_i,       // Signal sources, codes 1..22
   input  wire logic        sibling_ovf_i,   // Sibling timer overflow
   output logic             overflow_o,      // Own period match pulse
   output logic             window_o,        // Selected window level
   output logic             signal_o         // Selected signal level
);
   ////////////////////////////////////////////////////////////////////
   // Registers
   mtsr_pkg::mtsr_apb_s  apb;
   mtsr_pkg::mtsr_word_t count_q, count_d;
   mtsr_pkg::mtsr_word_t period_q;
   mtsr_pkg::mtsr_word_t cperiod_q, cwidth_q;
   mtsr_pkg::mtsr_code_t win_code_q, sig_code_q;
   mtsr_pkg::mtsr_state_e state_q, state_d;
   logic                 en_q, halt_q, go_q;
   logic                 prup_q, pwup_q, match_q;
   logic [31:0]          rdata_q;
   logic [23:0]          width_run_q;
   logic                 win_sel, sig_sel, sig_rise;

   assign apb = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                  addr: paddr_i, wdata: pwdata_i};

   ////////////////////////////////////////////////////////////////////
   // Address decode, zero-wait slave
   wire [11:0] idx       = apb.addr[13:2];
   wire        acc       = apb.sel & apb.enable;
   wire        wr        = acc & apb.write;
   wire        hit_count = (idx == `MTSR_IDX_COUNT);
   wire        hit_cper  = (idx == `MTSR_IDX_CPERIOD);
   wire        hit_cwid  = (idx == `MTSR_IDX_CWIDTH);
   wire        hit_per   = (idx == `MTSR_IDX_PERIOD);
   wire        hit_ctrl  = (idx == `MTSR_IDX_CTRL);
   wire        hit_stat  = (idx == `MTSR_IDX_STATUS);
   wire        hit_sig   = (idx == `MTSR_IDX_SIGSEL);
   wire        hit_win   = (idx == `MTSR_IDX_WINSEL);
   wire        hit_any   = hit_count | hit_cper | hit_cwid | hit_per |
                           hit_ctrl | hit_stat | hit_sig | hit_win;
   wire        mis_align = (apb.addr[1:0] != 2'b00);
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & (~hit_any | mis_align);
   wire        wr_ok     = wr & hit_any & ~mis_align;

   ////////////////////////////////////////////////////////////////////
   // Window selector
   // Code zero is routed pin
   mtsr_src_mux #(.N_SRC(25), .FIRST_RSV(`MTSR_WIN_FIRST_RSV)) u_win (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .src_i   ({win_src_i[22:21], sibling_ovf_i, win_src_i[20:0], window_pin_i}),
      .code_i  (win_code_q),
      .sel_o   (win_sel)
   );

   // Signal selector
   // Sibling overflow at 10111
   mtsr_src_mux #(.N_SRC(24), .FIRST_RSV(`MTSR_SIG_FIRST_RSV)) u_sig (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .src_i   ({sibling_ovf_i, sig_src_i, signal_pin_i}),
      .code_i  (sig_code_q),
      .sel_o   (sig_sel)
   );

   mtsr_edge u_edge (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .lvl_i   (sig_sel),
      .rise_o  (sig_rise)
   );
   assign window_o = win_sel;
   assign signal_o = sig_sel;

   ////////////////////////////////////////////////////////////////////
   // Counter control
   wire at_match = (count_q == period_q);
   wire tick     = (state_q == mtsr_pkg::MTSR_RUN);
   wire cnt_wr   = wr_ok & hit_count;
   wire en_drop  = wr_ok & hit_ctrl & ~apb.wdata[`MTSR_CTRL_EN];

   always_comb begin
      state_d = state_q;
      case (state_q)
         mtsr_pkg::MTSR_IDLE: if (en_q && go_q) state_d = mtsr_pkg::MTSR_RUN;
         mtsr_pkg::MTSR_RUN: begin
            if (!en_q || !go_q) state_d = mtsr_pkg::MTSR_IDLE;
            else if (at_match && halt_q) state_d = mtsr_pkg::MTSR_HALT;
         end
         mtsr_pkg::MTSR_HALT: if (!en_q || !go_q || cnt_wr) state_d = mtsr_pkg::MTSR_IDLE;
         default: state_d = mtsr_pkg::MTSR_IDLE;
      endcase
   end

   // Next count value
   always_comb begin
      count_d = count_q;
      if (cnt_wr) begin
         count_d = apb.wdata[23:0];
      end else if (tick) begin
         if (at_match) count_d = halt_q ? count_q : `MTSR_COUNT_RST;
         else count_d = count_q + 24'h000001;
      end
   end

   // Enable clear resets state
   // Disabled count stays writable; only the clearing write zeroes it
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         count_q <= `MTSR_COUNT_RST;
         state_q <= mtsr_pkg::MTSR_IDLE;
      end else if (en_drop || !en_q) begin
         count_q <= en_drop ? `MTSR_COUNT_RST : count_d;
         state_q <= mtsr_pkg::MTSR_IDLE;
      end else begin
         count_q <= count_d;
         state_q <= state_d;
      end
   end

   assign overflow_o = tick & at_match;

   ////////////////////////////////////////////////////////////////////
   // Control, selection and period registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         en_q       <= 1'b0;
         halt_q     <= 1'b0;
         go_q       <= 1'b0;
         period_q   <= `MTSR_PERIOD_RST;
         win_code_q <= 5'h00;
         sig_code_q <= 5'h00;
      end else if (wr_ok) begin
         if (hit_ctrl) begin
            en_q   <= apb.wdata[`MTSR_CTRL_EN];
            halt_q <= apb.wdata[`MTSR_CTRL_HALT];
            go_q   <= apb.wdata[`MTSR_CTRL_GO];
         end
         if (hit_per) period_q <= apb.wdata[23:0];
         if (hit_sig) sig_code_q <= apb.wdata[`MTSR_SEL_MSB:0];
         if (hit_win) win_code_q <= apb.wdata[`MTSR_SEL_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status flags; hardware set wins over software clear
   wire match_set = overflow_o;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !en_q) begin
         prup_q  <= 1'b0;
         pwup_q  <= 1'b0;
         match_q <= 1'b0;
      end else begin
         prup_q  <= (wr_ok && hit_stat) ? apb.wdata[`MTSR_STAT_PRUP] : 1'b0;
         pwup_q  <= (wr_ok && hit_stat) ? apb.wdata[`MTSR_STAT_PWUP] : 1'b0;
         if (match_set) match_q <= 1'b1;
         else if (wr_ok && hit_stat && !apb.wdata[`MTSR_STAT_MATCH]) match_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Captured results; only power-on reset clears them, running width also clears on signal rise or disable
   // Power-on clears them to zero
   always_ff @(posedge mclk_i) begin
      if (!por_n_i) begin
         width_run_q <= 24'h000000;
      end else if (sig_rise || !en_q) begin
         width_run_q <= 24'h000000;
      end else if (sig_sel) begin
         width_run_q <= width_run_q + 24'h000001;
      end
   end

   // Period captured on request or match
   always_ff @(posedge mclk_i) begin
      if (!por_n_i) begin
         cperiod_q <= 24'h000000;
         cwidth_q  <= 24'h000000;
      end else begin
         if (prup_q || overflow_o) cperiod_q <= count_q;
         if (pwup_q) cwidth_q <= width_run_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data mux, registered for the access phase
   wire [31:0] rd_mux =
        hit_count ? {8'h00, count_q} :
        hit_cper  ? {8'h00, cperiod_q} :
        hit_cwid  ? {8'h00, cwidth_q} :
        hit_per   ? {8'h00, period_q} :
        hit_ctrl  ? {24'h000000, en_q, 1'b0, halt_q, 4'h0, go_q} :
        hit_stat  ? {24'h000000, prup_q, pwup_q, 5'h00, match_q} :
        hit_sig   ? {27'h0000000, sig_code_q} :
        hit_win   ? {27'h0000000, win_code_q} : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) rdata_q <= 32'h00000000;
      else if (apb.sel && !apb.enable && !apb.write) rdata_q <= rd_mux;
   end
   assign prdata_o = rdata_q;
endmodule : mtsr_top

// *** mtsr_top_asserts.sv ***
// Port checker for the measurement timer top level
`include "mtsr_regs.svh"
module mtsr_top_asserts (
   input wire logic        mclk_i,        // Clock
   input wire logic        rst_n_i,       // Reset
   input wire logic        por_n_i,       // Power-on
   input wire logic        psel_i,        // Select
   input wire logic        penable_i,     // Enable
   input wire logic        pwrite_i,      // Write
   input wire logic [13:0] paddr_i,       // Address
   input wire logic [31:0] pwdata_i,      // Write data
   input wire logic [31:0] prdata_o,      // Read data
   input wire logic        pready_o,      // Ready
   input wire logic        pslverr_o,     // Error
   input wire logic        window_pin_i,  // Window pin
   input wire logic        signal_pin_i,  // Signal pin
   input wire logic [22:0] win_src_i,     // Window sources
   input wire logic [21:0] sig_src_i,     // Signal sources
   input wire logic        sibling_ovf_i, // Sibling overflow
   input wire logic        overflow_o,    // Match pulse
   input wire logic        window_o,      // Window level
   input wire logic        signal_o       // Signal level
);
   logic [4:0] w_q;
   logic [4:0] s_q;
   logic [2:0] age_q;
   // Accepted writes to the select words
   wire        wr = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
   wire        hw = wr & (paddr_i == {`MTSR_IDX_WINSEL, 2'b00});
   wire        hs = wr & (paddr_i == {`MTSR_IDX_SIGSEL, 2'b00});
   wire        st = (age_q == 3'h7);
   wire [4:0]  wi = w_q - ((w_q > 5'h16) ? 5'h2 : 5'h1);
   // Shadow codes; age hides the settling cycles
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         w_q   <= 5'h0;
         s_q   <= 5'h0;
         age_q <= 3'h0;
      end else begin
         if (hw) w_q <= pwdata_i[4:0];
         if (hs) s_q <= pwdata_i[4:0];
         if (hw | hs) age_q <= 3'h1;
         else if ((age_q != 3'h0) && !st) age_q <= age_q + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_win_pin; st && w_q == 5'h00 |-> window_o == $past(window_pin_i, 3); endproperty
   property p_win_map;
      st && (w_q inside {[5'h01:5'h15], 5'h17, 5'h18}) |-> window_o == $past(win_src_i[wi], 3);
   endproperty
   property p_win_ovf; st && w_q == 5'h16 |-> window_o == $past(sibling_ovf_i, 3); endproperty
   property p_win_rsv; st && w_q > 5'h18 |-> !window_o [*2]; endproperty
   property p_sig_pin; st && s_q == 5'h00 |-> signal_o == $past(signal_pin_i, 3); endproperty
   property p_sig_map;
      st && (s_q inside {[5'h01:5'h16]}) |-> signal_o == $past(sig_src_i[s_q - 5'h01], 3);
   endproperty
   property p_sig_ovf; st && s_q == 5'h17 |-> signal_o == $past(sibling_ovf_i, 3); endproperty
   property p_sig_rsv; st && s_q > 5'h17 |-> !signal_o; endproperty
   property p_cnt_ok;
      psel_i && !penable_i && paddr_i == {`MTSR_IDX_COUNT, 2'b00} |=> pready_o && !pslverr_o;
   endproperty
   a_win_pin: assert property (p_win_pin) else $error("window pin not routed");
   a_win_map: assert property (p_win_map) else $error("window source wrong");
   a_win_ovf: assert property (p_win_ovf) else $error("window sibling wrong");
   a_win_rsv: assert property (p_win_rsv) else $error("window reserved active");
   a_sig_pin: assert property (p_sig_pin) else $error("signal pin not routed");
   a_sig_map: assert property (p_sig_map) else $error("signal source wrong");
   a_sig_ovf: assert property (p_sig_ovf) else $error("signal sibling wrong");
   a_sig_rsv: assert property (p_sig_rsv) else $error("signal reserved active");
   a_cnt_ok: assert property (p_cnt_ok) else $error("count access refused");
   c_sib: cover property (st && w_q == 5'h16);
   c_rsv: cover property (st && s_q > 5'h17);
   c_ovf: cover property (overflow_o);
endmodule : mtsr_top_asserts

bind mtsr_top mtsr_top_asserts u_chk (.mclk_i, .rst_n_i, .por_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .window_pin_i,
   .signal_pin_i, .win_src_i, .sig_src_i, .sibling_ovf_i, .overflow_o, .window_o, .signal_o);

// *** tb_measure_timer_source_and_results.sv ***
// Self-checking bench for the measurement timer
`include "mtsr_regs.svh"
module tb_measure_timer_source_and_results;
   timeunit 1ns;
   timeprecision 1ps;
   logic                mclk_i = 1'b0;
   logic                rst_n_i = 1'b0;
   logic                por_n_i = 1'b0;
   mtsr_pkg::mtsr_apb_s req = '0;
   logic [31:0]         prdata_o;
   logic                pready_o, pslverr_o, overflow_o, window_o, signal_o, e;
   logic [47:0]         src;
   logic [47:0]         hq[$];
   logic [4:0]          wc = 5'h0, sc = 5'h0;
   logic [31:0]         rd, v;
   logic [11:0]         ro[2] = '{`MTSR_IDX_CWIDTH, `MTSR_IDX_CPERIOD};
   logic                chk_en = 1'b0;
   int                  miscompares = 0, n_compared = 0, cyc = 0, k;
   int                  seed = 32'hbe25e22f;

   initial forever #2 mclk_i = ~mclk_i;
   mtsr_src_model u_src (.mclk_i, .src_o(src));
   mtsr_top dut (.mclk_i, .rst_n_i, .por_n_i, .psel_i(req.sel), .penable_i(req.enable),
      .pwrite_i(req.write), .paddr_i(req.addr), .pwdata_i(req.wdata), .prdata_o, .pready_o,
      .pslverr_o, .window_pin_i(src[46]), .signal_pin_i(src[45]), .win_src_i(src[44:22]),
      .sig_src_i(src[21:0]), .sibling_ovf_i(src[47]), .overflow_o, .window_o, .signal_o);

   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
      @(posedge mclk_i);
      req <= '{1'b1, 1'b0, w, {i, 2'b00}, d};
      @(posedge mclk_i);
      req.enable <= 1'b1;
      // The wait ends when pready_o is high; the hang guard ends it otherwise
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      e = pslverr_o;
      req <= '0;
   endtask : apb
   task automatic wait_ovf();
      for (k = 1; k < 40; k++) begin
         @(negedge mclk_i);
         if (overflow_o === 1'b1) break;
      end
   endtask : wait_ovf
   function automatic logic ew(logic [4:0] c, logic [47:0] b);
      if (c == 5'h00) return b[46];
      if (c == 5'h16) return b[47];
      if (c > 5'h18) return 1'b0;
      return (c > 5'h16) ? b[20 + c] : b[21 + c];
   endfunction : ew
   function automatic logic es(logic [4:0] c, logic [47:0] b);
      if (c == 5'h00) return b[45];
      if (c == 5'h17) return b[47];
      if (c > 5'h17) return 1'b0;
      return b[c - 1];
   endfunction : es
   ////////////////////////////////////////////////////////////
   // selector model
   always @(negedge mclk_i) begin
      hq.push_front(src);
      if (hq.size() > 4) void'(hq.pop_back());
      if (chk_en) begin
         chk({31'h0, window_o}, {31'h0, ew(wc, hq[3])}, "window level");
         chk({31'h0, signal_o}, {31'h0, es(sc, hq[3])}, "signal level");
      end
   end
   // Hang guard
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      por_n_i <= 1'b1;
      apb(1'b0, `MTSR_IDX_COUNT, 32'h0);
      chk(rd, 32'h0, "count reset");
      v = $random(seed);
      apb(1'b1, `MTSR_IDX_COUNT, v);
      apb(1'b0, `MTSR_IDX_COUNT, 32'h0);
      chk(rd, {8'h00, v[23:0]}, "count readback");
      apb(1'b0, 12'h000, 32'h0);
      chk({e, rd[30:0]}, 32'h80000000, "unmapped read");
      apb(1'b1, `MTSR_IDX_PERIOD, 32'h5);
      apb(1'b1, `MTSR_IDX_COUNT, 32'h0);
      apb(1'b1, `MTSR_IDX_CTRL, 32'h81);
      wait_ovf();
      wait_ovf();
      chk(k, 32'h6, "match spacing");
      apb(1'b1, `MTSR_IDX_STATUS, 32'h80);
      apb(1'b0, `MTSR_IDX_STATUS, 32'h0);
      chk({31'h0, rd[7]}, 32'h0, "load request");
      apb(1'b0, `MTSR_IDX_CPERIOD, 32'h0);
      chk(rd & 32'hfffffff8, 32'h0, "captured range");
      // Halt on match keeps the count at the period value
      apb(1'b1, `MTSR_IDX_PERIOD, 32'h3);
      apb(1'b1, `MTSR_IDX_COUNT, 32'h0);
      apb(1'b1, `MTSR_IDX_CTRL, 32'ha1);
      repeat (12) @(posedge mclk_i);
      apb(1'b0, `MTSR_IDX_COUNT, 32'h0);
      chk({overflow_o, rd[30:0]}, 32'h3, "halt at match");
      apb(1'b1, `MTSR_IDX_CTRL, 32'h0);
      apb(1'b0, `MTSR_IDX_COUNT, 32'h0);
      chk({overflow_o, rd[30:0]}, 32'h0, "disable clears");
      foreach (ro[j]) begin
         apb(1'b0, ro[j], 32'h0);
         v = rd;
         apb(1'b1, ro[j], ~v);
         apb(1'b0, ro[j], 32'h0);
         chk(rd, v, "read-only word");
      end
      apb(1'b1, `MTSR_IDX_COUNT, 32'h123456);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, `MTSR_IDX_CPERIOD, 32'h0);
      chk(rd, v, "kept over reset");
      apb(1'b0, `MTSR_IDX_COUNT, 32'h0);
      chk(rd, 32'h0, "count cleared");
      for (int c = 0; c < 32; c++) begin
         v = $random(seed);
         wc = c[4:0];
         sc = 5'h1f - wc;
         apb(1'b1, `MTSR_IDX_WINSEL, {v[31:5], wc});
         apb(1'b1, `MTSR_IDX_SIGSEL, {v[31:5], sc});
         apb(1'b0, `MTSR_IDX_SIGSEL, 32'h0);
         chk({27'h0, rd[4:0]}, {27'h0, sc}, "signal code");
         repeat (6) @(posedge mclk_i);
         chk_en = 1'b1;
         repeat (8) @(posedge mclk_i);
         chk_en = 1'b0;
      end
      stop_test();
   end
endmodule : tb_measure_timer_source_and_results
